/* src/nec_cfg.svh */
// Constants for the NAND erase and copyback command sequencer.
`ifndef NEC_CFG_SVH
`define NEC_CFG_SVH
// Command codes.
`define NEC_C_ERASE     8'h60
`define NEC_C_ERASE_GO  8'hd0
`define NEC_C_ERASE_Q   8'hd1
`define NEC_C_READ      8'h00
`define NEC_C_READ_GO   8'h30
`define NEC_C_READ_Q    8'h32
`define NEC_C_CB_READ   8'h35
`define NEC_C_PROG      8'h80
`define NEC_C_CB_PROG   8'h85
`define NEC_C_PROG_GO   8'h10
`define NEC_C_PROG_Q    8'h11
`define NEC_C_STAT      8'h70
`define NEC_C_STAT_ENH  8'h78
`define NEC_C_COL_RD    8'h05
`define NEC_C_COL_ENH   8'h06
`define NEC_C_COL_GO    8'he0
`define NEC_C_RST       8'hff
`define NEC_C_RST_SYNC  8'hfc
// Address cycle counts.
`define NEC_ROW_CYC     3'h3
`define NEC_PAGE_CYC    3'h5
`define NEC_COL_CYC     3'h2
// Register byte offsets.
`define NEC_A_CMD       8'h00
`define NEC_A_ADDR      8'h04
`define NEC_A_DATA      8'h08
`define NEC_A_STATUS    8'h0c
`define NEC_A_ROW       8'h10
`define NEC_A_QUEUE     8'h14
// Status and queue field positions.
`define NEC_S_FAIL      0
`define NEC_S_RDY       1
`define NEC_S_ARRAY_READY_FLAG      2
`define NEC_S_CB        3
`define NEC_S_REJ       4
`define NEC_Q_ERASE     0
`define NEC_Q_PROG      8
`define NEC_Q_CACHE     16
`define NEC_Q_READ      24
// Timing in nanoseconds and clock period.
`define NEC_CLK_NS      4
`define NEC_T_BERS_NS   2000000
`define NEC_T_DBSY_NS   500
`define NEC_T_R_NS      25000
`define NEC_T_PROG_NS   300000
`endif

/* src/nec_pkg.sv */
// Types shared by the NAND erase and copyback command sequencer.
package nec_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ERA = 3'b001, S_ERC = 3'b010, S_RDA = 3'b011,
    S_RDC  = 3'b100, S_PGA = 3'b101, S_PGD = 3'b110, S_COL = 3'b111
  } nec_state_type;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_ERASE = 3'b001, OP_PROG = 3'b010,
    OP_READ = 3'b011, OP_QUEUE = 3'b100
  } nec_op_type;
endpackage : nec_pkg

/* src/nec_sequencer.sv */
// APB-controlled erase and copyback command sequencer of one NAND die.
//
// Notes on behaviour
// - Erase is 60h, three row cycles with page bits ignored, then D0h.
// - Erase sequences are accepted only while both ready flags are set.
// - D0h clears both ready flags for the block erase time, erasing queued blocks.
// - Queue entry is 60h, three row cycles, D1h, then short queue busy.
// - Each D1h queues its plane; D0h adds its block and erases all.
// - Copyback is 00h-35h read, wait ready, then 85h-10h program.
// - Copyback read behaves as page read with confirm 35h instead of 30h.
// - 85h opens a program without clearing the cache registers.
// - 85h-11h queues like 80h-11h but keeps the cache registers.
// - Multi-plane copyback read is 00h-32h entries then 00h-35h.
// - Multi-plane copyback program is 85h-11h entries then 85h-10h.
// - Between copyback read and program only status and column commands.
// - Reset after copyback read invalidates the cache registers.
// - A plain 80h with no queued program clears every cache register.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "nec_cfg.svh"
module nec_sequencer #(
  parameter int unsigned PL        = 2,   // Planes, at most eight.
  parameter int unsigned PAGE_BITS = 8,   // Page bits at the bottom of the row.
  parameter int unsigned BERS_CYC  = (`NEC_T_BERS_NS + `NEC_CLK_NS - 1) / `NEC_CLK_NS,
  parameter int unsigned DBSY_CYC  = (`NEC_T_DBSY_NS + `NEC_CLK_NS - 1) / `NEC_CLK_NS,
  parameter int unsigned READ_CYC  = (`NEC_T_R_NS + `NEC_CLK_NS - 1) / `NEC_CLK_NS,
  parameter int unsigned PROG_CYC  = (`NEC_T_PROG_NS + `NEC_CLK_NS - 1) / `NEC_CLK_NS
) (
  input  wire logic        i_clk,        // Clock, 250 MHz.
  input  wire logic        i_reset,      // Synchronous reset, active high.
  input  wire logic        i_ce,         // Clock enable, freezes all state.
  input  wire logic        i_psel,       // APB select.
  input  wire logic        i_penable,    // APB enable.
  input  wire logic        i_pwrite,     // APB direction.
  input  wire logic [7:0]  i_paddr,      // APB byte address.
  input  wire logic [31:0] i_pwdata,     // APB write data.
  input  wire logic        i_array_fail, // Array outcome at end of busy.
  output logic      [31:0] o_prdata,     // APB read data.
  output logic             o_pready,     // APB ready.
  output logic             o_pslverr,    // APB error on unmapped address.
  output logic             o_ready       // Ready/busy pin level, high = ready.
);

  localparam int unsigned PB = (PL > 1) ? $clog2(PL) : 1;

  typedef struct packed {
    nec_pkg::nec_state_type st;
    nec_pkg::nec_op_type    op;
    logic [2:0]             acnt;
    logic [23:0]            row;
    logic [31:0]            cnt;
    logic                   fail;
    logic                   cb;
    logic                   rej;
    logic [PL-1:0]          eq;
    logic [PL-1:0]          pq;
    logic [PL-1:0]          rq;
    logic [PL-1:0]          cv;
    logic [31:0]            rdata;
    logic                   slverr;
  } nec_regs_type;

  nec_regs_type s_reg;
  nec_regs_type s_next;

  // One-hot plane of a row address.
  function automatic logic [PL-1:0] plane_of(input logic [23:0] row);
    logic [PL-1:0] oh;
    oh = '0;
    oh[row[PAGE_BITS +: PB]] = 1'b1;
    return oh;
  endfunction : plane_of
  // Status command code, legal at any time.
  function automatic logic is_stat(input logic [7:0] c);
    return (c == `NEC_C_STAT) || (c == `NEC_C_STAT_ENH);
  endfunction : is_stat
  // Reset command code.
  function automatic logic is_rst(input logic [7:0] c);
    return (c == `NEC_C_RST) || (c == `NEC_C_RST_SYNC);
  endfunction : is_rst

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic       acc;
  logic       setup;
  logic       cmd_wr;
  logic       adr_wr;
  logic       dat_wr;
  logic       busy;
  logic [7:0] wd;
  // Setup and access phase strobes and the byte carried by a write.
  assign acc    = i_psel & i_penable & i_ce;
  assign setup  = i_psel & ~i_penable & i_ce;
  assign cmd_wr = acc & i_pwrite & (i_paddr == `NEC_A_CMD);
  assign adr_wr = acc & i_pwrite & (i_paddr == `NEC_A_ADDR);
  assign dat_wr = acc & i_pwrite & (i_paddr == `NEC_A_DATA);
  assign wd     = i_pwdata[7:0];
  assign busy   = (s_reg.op != nec_pkg::OP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  // Sequencing, busy timing and register read-back.
  always_comb begin
    s_next = s_reg;
    // Busy countdown; the array outcome is taken on the last busy cycle.
    if (busy) begin
      if (s_reg.cnt == '0) begin
        s_next.op = nec_pkg::OP_NONE;
        case (s_reg.op)
          nec_pkg::OP_ERASE: begin
            s_next.fail = i_array_fail;
            s_next.eq   = '0;
          end
          nec_pkg::OP_PROG: begin
            s_next.fail = i_array_fail;
            s_next.pq   = '0;
          end
          default: begin end
        endcase
      end else begin
        s_next.cnt = s_reg.cnt - 32'h1;
      end
    end
    // Command cycles.
    if (cmd_wr) begin
      s_next.rej = 1'b0;
      if (is_rst(wd)) begin
        // Reset aborts work and leaves the cache registers invalid.
        s_next.st   = nec_pkg::S_IDLE;
        s_next.op   = nec_pkg::OP_NONE;
        s_next.eq   = '0;
        s_next.pq   = '0;
        s_next.rq   = '0;
        s_next.cv   = '0;
        s_next.cb   = 1'b0;
      end else if (busy && !is_stat(wd)) begin
        s_next.rej = 1'b1;
      end else if (!is_stat(wd)) begin
        case (s_reg.st)
          nec_pkg::S_IDLE: begin
            s_next.acnt = '0;
            case (wd)
              `NEC_C_ERASE: begin
                if (s_reg.cb) s_next.rej = 1'b1;
                else s_next.st = nec_pkg::S_ERA;
              end
              `NEC_C_READ: begin
                if (s_reg.cb) s_next.rej = 1'b1;
                else s_next.st = nec_pkg::S_RDA;
              end
              `NEC_C_PROG: begin
                if (s_reg.cb) begin
                  s_next.rej = 1'b1;
                end else begin
                  s_next.st = nec_pkg::S_PGA;
                  if (s_reg.pq == '0) s_next.cv = '0;
                end
              end
              `NEC_C_CB_PROG: begin
                s_next.st = nec_pkg::S_PGA;
              end
              `NEC_C_COL_RD, `NEC_C_COL_ENH: begin
                s_next.st = nec_pkg::S_COL;
              end
              default: begin
                s_next.rej = 1'b1;
              end
            endcase
          end
          nec_pkg::S_ERC: begin
            s_next.st = nec_pkg::S_IDLE;
            if (wd == `NEC_C_ERASE_GO) begin
              s_next.eq  = s_reg.eq | plane_of(s_reg.row);
              s_next.op  = nec_pkg::OP_ERASE;
              s_next.cnt = 32'(BERS_CYC - 1);
            end else if (wd == `NEC_C_ERASE_Q) begin
              s_next.eq  = s_reg.eq | plane_of(s_reg.row);
              s_next.op  = nec_pkg::OP_QUEUE;
              s_next.cnt = 32'(DBSY_CYC - 1);
            end else begin
              s_next.rej = 1'b1;
            end
          end
          nec_pkg::S_RDC: begin
            s_next.st = nec_pkg::S_IDLE;
            if ((wd == `NEC_C_READ_GO) || (wd == `NEC_C_CB_READ)) begin
              s_next.cv  = s_reg.cv | s_reg.rq | plane_of(s_reg.row);
              s_next.rq  = '0;
              s_next.cb  = (wd == `NEC_C_CB_READ);
              s_next.op  = nec_pkg::OP_READ;
              s_next.cnt = 32'(READ_CYC - 1);
            end else if (wd == `NEC_C_READ_Q) begin
              s_next.rq  = s_reg.rq | plane_of(s_reg.row);
              s_next.op  = nec_pkg::OP_QUEUE;
              s_next.cnt = 32'(DBSY_CYC - 1);
            end else begin
              s_next.rej = 1'b1;
            end
          end
          nec_pkg::S_PGA, nec_pkg::S_PGD: begin
            if (wd == `NEC_C_CB_PROG) begin
              // Column or row change inside data input keeps the cache.
              s_next.st   = nec_pkg::S_PGA;
              s_next.acnt = '0;
            end else if ((s_reg.st == nec_pkg::S_PGD) && (wd == `NEC_C_PROG_GO)) begin
              s_next.st  = nec_pkg::S_IDLE;
              s_next.pq  = s_reg.pq | plane_of(s_reg.row);
              s_next.cb  = 1'b0;
              s_next.op  = nec_pkg::OP_PROG;
              s_next.cnt = 32'(PROG_CYC - 1);
            end else if ((s_reg.st == nec_pkg::S_PGD) && (wd == `NEC_C_PROG_Q)) begin
              s_next.st  = nec_pkg::S_IDLE;
              s_next.pq  = s_reg.pq | plane_of(s_reg.row);
              s_next.op  = nec_pkg::OP_QUEUE;
              s_next.cnt = 32'(DBSY_CYC - 1);
            end else begin
              s_next.st  = nec_pkg::S_IDLE;
              s_next.rej = 1'b1;
            end
          end
          nec_pkg::S_COL: begin
            s_next.st  = nec_pkg::S_IDLE;
            s_next.rej = (wd != `NEC_C_COL_GO);
          end
          default: begin
            s_next.st  = nec_pkg::S_IDLE;
            s_next.rej = 1'b1;
          end
        endcase
      end
    end
    // Address cycles; the last three bytes taken form the row.
    if (adr_wr) begin
      case (s_reg.st)
        nec_pkg::S_ERA: begin
          s_next.row  = {wd, s_reg.row[23:8]};
          s_next.acnt = s_reg.acnt + 3'h1;
          if (s_reg.acnt == `NEC_ROW_CYC - 3'h1) s_next.st = nec_pkg::S_ERC;
        end
        nec_pkg::S_RDA, nec_pkg::S_PGA: begin
          s_next.row  = {wd, s_reg.row[23:8]};
          s_next.acnt = s_reg.acnt + 3'h1;
          if (s_reg.acnt == `NEC_PAGE_CYC - 3'h1) begin
            s_next.st = (s_reg.st == nec_pkg::S_RDA) ? nec_pkg::S_RDC : nec_pkg::S_PGD;
          end
        end
        nec_pkg::S_COL: begin
          s_next.acnt = s_reg.acnt + 3'h1;
        end
        default: begin
          s_next.rej = 1'b1;
        end
      endcase
    end
    // Data input; after a column change the data phase resumes once two column cycles are taken.
    if (dat_wr) begin
      if ((s_reg.st == nec_pkg::S_PGA) && (s_reg.acnt >= `NEC_COL_CYC)) begin
        s_next.st = nec_pkg::S_PGD;
      end else if (s_reg.st != nec_pkg::S_PGD) begin
        s_next.rej = 1'b1;
      end
    end
    // Read data and error are prepared in the setup phase.
    if (setup) begin
      s_next.rdata  = '0;
      s_next.slverr = 1'b0;
      case (i_paddr)
        `NEC_A_STATUS: begin
          s_next.rdata[`NEC_S_FAIL] = s_reg.fail;
          s_next.rdata[`NEC_S_RDY]  = ~busy;
          s_next.rdata[`NEC_S_ARRAY_READY_FLAG] = ~busy;
          s_next.rdata[`NEC_S_CB]   = s_reg.cb;
          s_next.rdata[`NEC_S_REJ]  = s_reg.rej;
        end
        `NEC_A_ROW: begin
          s_next.rdata[23:0] = s_reg.row;
        end
        `NEC_A_QUEUE: begin
          s_next.rdata[`NEC_Q_ERASE +: PL] = s_reg.eq;
          s_next.rdata[`NEC_Q_PROG +: PL]  = s_reg.pq;
          s_next.rdata[`NEC_Q_CACHE +: PL] = s_reg.cv;
          s_next.rdata[`NEC_Q_READ +: PL]  = s_reg.rq;
        end
        `NEC_A_CMD, `NEC_A_ADDR, `NEC_A_DATA: begin
          s_next.rdata = '0;
        end
        default: begin
          s_next.slverr = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  // All state is held here and frozen while the clock enable is low.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_reg <= '0;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs.
  assign o_prdata  = s_reg.rdata;
  assign o_pslverr = s_reg.slverr;
  assign o_pready  = 1'b1;
  assign o_ready   = ~busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb_clk @(posedge i_clk); endclocking
  default disable iff (i_reset);

  logic idle_rdy;
  assign idle_rdy = (s_reg.st == nec_pkg::S_IDLE) && !busy && !s_reg.cb;

  erase_row_cycles_a: assert property (
    (s_reg.st == nec_pkg::S_ERA) && adr_wr && (s_reg.acnt == `NEC_ROW_CYC - 3'h1)
    |=> (s_reg.st == nec_pkg::S_ERC)
  ) else $error("erase did not end address phase after three rows");
  erase_busy_gate_a: assert property (
    busy && cmd_wr && (wd == `NEC_C_ERASE)
    |=> s_reg.rej && (s_reg.st == $past(s_reg.st))
  ) else $error("erase accepted while busy");
  erase_go_busy_a: assert property (
    !busy && (s_reg.st == nec_pkg::S_ERC) && cmd_wr && (wd == `NEC_C_ERASE_GO)
    |=> !o_ready && (s_reg.op == nec_pkg::OP_ERASE) && (s_reg.cnt == 32'(BERS_CYC - 1))
  ) else $error("erase confirm did not start block erase busy");
  queue_busy_time_a: assert property (
    !busy && (s_reg.st == nec_pkg::S_ERC) && cmd_wr && (wd == `NEC_C_ERASE_Q)
    |=> (s_reg.op == nec_pkg::OP_QUEUE) && (s_reg.cnt == 32'(DBSY_CYC - 1))
  ) else $error("queue entry did not start short busy");
  erase_queue_add_a: assert property (
    !busy && (s_reg.st == nec_pkg::S_ERC) && cmd_wr && (wd == `NEC_C_ERASE_Q)
    |=> s_reg.eq == ($past(s_reg.eq) | plane_of($past(s_reg.row)))
  ) else $error("queue entry did not add its plane");
  cb_read_mark_a: assert property (
    !busy && (s_reg.st == nec_pkg::S_RDC) && cmd_wr && (wd == `NEC_C_CB_READ)
    |=> s_reg.cb && (s_reg.op == nec_pkg::OP_READ) && (s_reg.cnt == 32'(READ_CYC - 1))
  ) else $error("copyback read not handled as page read");
  cb_prog_keep_a: assert property (
    (s_reg.st == nec_pkg::S_IDLE) && !busy && cmd_wr && (wd == `NEC_C_CB_PROG)
    |=> (s_reg.cv == $past(s_reg.cv)) && (s_reg.st == nec_pkg::S_PGA)
  ) else $error("copyback program opening changed the cache");
  cb_only_allowed_a: assert property (
    s_reg.cb && !busy && (s_reg.st == nec_pkg::S_IDLE) && cmd_wr && (wd == `NEC_C_ERASE)
    |=> s_reg.rej && (s_reg.st == nec_pkg::S_IDLE)
  ) else $error("forbidden command accepted during copyback");
  reset_invalid_a: assert property (
    cmd_wr && is_rst(wd) |=> (s_reg.cv == '0) && !s_reg.cb && o_ready
  ) else $error("reset left cache valid");
  prog_clears_a: assert property (
    idle_rdy && cmd_wr && (wd == `NEC_C_PROG) && (s_reg.pq == '0) |=> s_reg.cv == '0
  ) else $error("plain program did not clear cache");
  fail_update_a: assert property (
    i_ce && (s_reg.op == nec_pkg::OP_ERASE) && (s_reg.cnt == '0) && !cmd_wr
    |=> o_ready && (s_reg.fail == $past(i_array_fail))
  ) else $error("erase completion did not record fail");

endmodule : nec_sequencer

/* bench/nec_host_model.sv */
// Host controller model that runs one APB transfer for each bench request.
`timescale 1ns/1ps
module nec_host_model (
  input  wire logic        i_clk,     // Clock.
  input  wire logic        i_reset,   // Synchronous reset, active high.
  input  wire logic        i_go,      // Request one transfer.
  input  wire logic        i_wr,      // Direction of the request, 1 = write.
  input  wire logic [7:0]  i_addr,    // Byte address of the request.
  input  wire logic [31:0] i_wdata,   // Write data of the request.
  input  wire logic        i_pready,  // APB ready from the die.
  input  wire logic [31:0] i_prdata,  // APB read data from the die.
  output logic             o_psel,    // APB select.
  output logic             o_penable, // APB enable.
  output logic             o_pwrite,  // APB direction.
  output logic [7:0]       o_paddr,   // APB address.
  output logic [31:0]      o_pwdata,  // APB write data.
  output logic             o_done,    // One-cycle pulse after the transfer.
  output logic [31:0]      o_rdata    // Read data taken at the ready edge.
);
  //////////////////////////////////////////////////////////////////////////////
  // Setup, then access until ready; a released bus shows inverted values so stale data is never trusted.
  always_ff @(posedge i_clk) begin
    o_done <= !i_reset && o_penable && i_pready;
    if (i_reset) begin
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
    end else if (o_penable && i_pready) begin
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
      o_rdata   <= i_prdata;
      o_paddr   <= ~o_paddr;
      o_pwdata  <= ~o_pwdata;
      o_pwrite  <= ~o_pwrite;
    end else if (o_psel) begin
      o_penable <= 1'b1;
    end else if (i_go) begin
      o_psel    <= 1'b1;
      o_pwrite  <= i_wr;
      o_paddr   <= i_addr;
      o_pwdata  <= i_wdata;
    end
  end
endmodule : nec_host_model

/* bench/tb_nec_sequencer.sv */
// Self-checking bench for the erase and copyback command sequencer.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end
`define NEC_Z5 {WR, AA, 32'h0}, {WR, AA, 32'h0}, {WR, AA, 32'h0}, {WR, AA, 32'h0}, {WR, AA, 32'h0}
module tb_nec_sequencer;
  localparam int unsigned BERS = 20;
  localparam int unsigned DBSY = 5;
  localparam int unsigned RDC  = 10;
  localparam int unsigned PRGC = 15;
  localparam logic [1:0]  WR   = 2'h0;
  localparam logic [1:0]  RD   = 2'h1;
  localparam logic [1:0]  WT   = 2'h2;
  localparam logic [7:0]  CA   = 8'h00;
  localparam logic [7:0]  AA   = 8'h04;
  localparam logic [7:0]  DA   = 8'h08;
  localparam logic [7:0]  SA   = 8'h0c;
  localparam logic [7:0]  RA   = 8'h10;
  localparam logic [7:0]  QA   = 8'h14;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        fail_in = 1'b0;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        psel, penable, pwrite, pready, pslverr, ready, done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [41:0] rows [$];
  logic [41:0] r;
  int          miscompares = 0;
  int          total_checks = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  nec_sequencer #(.PL(2), .PAGE_BITS(8), .BERS_CYC(BERS), .DBSY_CYC(DBSY), .READ_CYC(RDC), .PROG_CYC(PRGC)) dut (
    .i_clk(clk), .i_reset(rst), .i_ce(ce), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_array_fail(fail_in), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_ready(ready));

  nec_host_model host (
    .i_clk(clk), .i_reset(rst), .i_go(go), .i_wr(wr), .i_addr(ad), .i_wdata(wd), .i_pready(pready),
    .i_prdata(prdata), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .o_done(done), .o_rdata(rd));

  //////////////////////////////////////////////////////////////////////////////
  // One bus transfer through the host model, bounded so a stuck bus cannot hang the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    go <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 50);
    `CHK("bus done", 1'b1, done)
    `CHK("apb ready", 1'b1, pready)
  endtask : bus

  // Counts busy cycles seen after the transfer that started them; the first one passes inside bus.
  task automatic wt(input logic [31:0] e);
    logic [31:0] n;
    n = 32'h0;
    while (n < 32'h200) begin
      @(posedge clk);
      if (ready === 1'b1) break;
      n++;
    end
    `CHK("busy cycles", e, n)
  endtask : wt

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected run of about six hundred cycles.
  initial begin
    #40000;
    miscompares++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Table of ordinary sequences, then hand-written awkward cases.
  initial begin
    rows = '{
      {WR, CA, 32'h60}, {WR, AA, 32'h05}, {WR, AA, 32'h01}, {WR, AA, 32'h00},
      {RD, RA, 32'h000105}, {WR, CA, 32'hd0}, {WT, CA, 32'(BERS - 1)}, {RD, SA, 32'h06},
      {WR, CA, 32'h60}, {WR, AA, 32'h00}, {WR, AA, 32'h00}, {WR, AA, 32'h00}, {WR, CA, 32'hd1},
      {WT, CA, 32'(DBSY - 1)}, {RD, QA, 32'h01}, {WR, CA, 32'h60}, {WR, AA, 32'h00},
      {WR, AA, 32'h01}, {WR, AA, 32'h00}, {WR, CA, 32'hd0}, {WT, CA, 32'(BERS - 1)},
      {RD, QA, 32'h0}, {RD, SA, 32'h06},
      {WR, CA, 32'h00}, `NEC_Z5, {WR, CA, 32'h32}, {WT, CA, 32'(DBSY - 1)}, {RD, QA, 32'h01000000},
      {WR, CA, 32'h00}, {WR, AA, 32'h00}, {WR, AA, 32'h00}, {WR, AA, 32'h00}, {WR, AA, 32'h01},
      {WR, AA, 32'h00}, {WR, CA, 32'h35}, {WT, CA, 32'(RDC - 1)}, {RD, SA, 32'h0e},
      {RD, QA, 32'h00030000}, {WR, CA, 32'h60}, {RD, SA, 32'h1e}, {WR, CA, 32'h70},
      {RD, SA, 32'h0e}, {WR, CA, 32'h05}, {WR, AA, 32'h00}, {WR, AA, 32'h00}, {WR, CA, 32'he0},
      {RD, SA, 32'h0e}, {WR, CA, 32'h85}, `NEC_Z5, {WR, DA, 32'ha5}, {WR, CA, 32'h11},
      {WT, CA, 32'(DBSY - 1)}, {RD, QA, 32'h00030100}, {WR, CA, 32'h85}, {WR, AA, 32'h00},
      {WR, AA, 32'h00}, {WR, AA, 32'h00}, {WR, AA, 32'h01}, {WR, AA, 32'h00}, {WR, CA, 32'h10},
      {WT, CA, 32'(PRGC - 1)}, {RD, SA, 32'h06}, {WR, CA, 32'h80}, {RD, QA, 32'h0},
      `NEC_Z5, {WR, CA, 32'h10}, {WT, CA, 32'(PRGC - 1)}, {RD, SA, 32'h06}, {RD, 8'h18, 32'h0}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Single die, so plain status is safe and no interleaved operation is ever started.
    foreach (rows[i]) begin
      r = rows[i];
      if (r[41:40] == WR) begin
        bus(1'b1, r[39:32], r[31:0]);
      end else if (r[41:40] == RD) begin
        bus(1'b0, r[39:32], 32'h0);
        `CHK("register read", r[31:0], rd)
      end else begin
        wt(r[31:0]);
      end
    end
    $display("test table done");
    // Failed erase, with the clock enable dropped mid-busy to stretch the wait.
    fail_in <= 1'b1;
    bus(1'b1, CA, 32'h60);
    repeat (3) bus(1'b1, AA, 32'h00);
    bus(1'b1, CA, 32'hd0);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("frozen busy", 1'b0, ready)
    ce <= 1'b1;
    wt(32'(BERS - 1));
    fail_in <= 1'b0;
    bus(1'b0, SA, 32'h0);
    `CHK("fail status", 32'h07, rd)
    $display("test erase fail done");
    // Erase refused while busy, then abort by reset command.
    bus(1'b1, CA, 32'h60);
    repeat (3) bus(1'b1, AA, 32'h00);
    bus(1'b1, CA, 32'hd0);
    bus(1'b1, CA, 32'h60);
    bus(1'b0, SA, 32'h0);
    `CHK("busy refusal", 4'h8, rd[4:1])
    bus(1'b1, CA, 32'hff);
    bus(1'b0, SA, 32'h0);
    `CHK("abort status", 4'h3, rd[4:1])
    `CHK("abort ready pin", 1'b1, ready)
    $display("test busy refusal done");
    // Reset command after copyback read leaves the cache invalid.
    bus(1'b1, CA, 32'h00);
    repeat (5) bus(1'b1, AA, 32'h00);
    bus(1'b1, CA, 32'h35);
    wt(32'(RDC - 1));
    bus(1'b1, CA, 32'hfc);
    bus(1'b0, SA, 32'h0);
    `CHK("pending after reset", 4'h3, rd[4:1])
    bus(1'b0, QA, 32'h0);
    `CHK("cache after reset", 32'h0, rd)
    $display("test copyback reset done");
    // Unmapped address raises the bus error.
    bus(1'b1, 8'h1c, 32'h0);
    `CHK("unmapped error", 1'b1, pslverr)
    bus(1'b0, SA, 32'h0);
    `CHK("mapped no error", 1'b0, pslverr)
    // Hardware reset in the middle of a pending copyback.
    bus(1'b1, CA, 32'h00);
    repeat (5) bus(1'b1, AA, 32'h00);
    bus(1'b1, CA, 32'h35);
    wt(32'(RDC - 1));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("ready after reset", 1'b1, ready)
    `CHK("read data after reset", 32'h0, prdata)
    bus(1'b0, QA, 32'h0);
    `CHK("queues after reset", 32'h0, rd)
    bus(1'b0, SA, 32'h0);
    `CHK("status after reset", 4'h3, rd[4:1])
    $display("test reset done");
    end_of_test();
  end
endmodule : tb_nec_sequencer
